// File: eio_param_regs.sv
// What this block does
// - each discrete fallback mode bit chooses, per output, level or hold.
// - each discrete fallback level bit gives the level driven in fallback.
// - the upper byte of both discrete registers affects no output.
// - every discrete fallback mode bit comes out of reset as one.
// - each analog range code is decoded into its signal kind.
// - unit selects the scale; custom min and max apply only for unit one.
// - inputs sit at offsets 0-7, accept range 0, 2, 3, with set defaults.
// - single output: mode at 4 with 0 apply and 1 hold, value at 5.
// - mixed module: output at 8-13, mode 1 apply and 0 hold, default 1.
// - resolution is fixed per type; unmixable types share one range.
//
// Purpose: parameter registers and fallback steering for expansion i/o
// Assumes: fallback_req comes from outside this clock domain
// Notes:   one write and one read handled at a time on axi4-lite
`timescale 1ns/10ps
module eio_param_regs #(
  parameter eio_pkg::eio_type_e MODULE_TYPE = eio_pkg::EIO_TWO_IN_OUT,
  parameter bit                 MIX_ALLOWED = 1'b1
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // axi4-lite write address and data
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // fallback request and output commands
  input  wire logic        fallback_req,
  input  wire logic [7:0]  disc_cmd,
  input  wire logic [15:0] ana_cmd,
  // driven outputs
  output logic [7:0]       disc_out,
  output logic [15:0]      ana_out,
  // per channel decode, channel c in bits [3c+2:3c] and [16c+15:16c]
  output logic [8:0]       range_kind,
  output logic [47:0]      scale_min,
  output logic [47:0]      scale_max
);

  localparam int NCH = 3;
  localparam bit ONE_OUT = (MODULE_TYPE == eio_pkg::EIO_ONE_OUT);
  localparam bit HAS_OUT = (MODULE_TYPE != eio_pkg::EIO_TWO_IN);
  localparam logic [5:0] SPAN =
    ONE_OUT ? eio_pkg::SPAN_ONE_OUT :
    HAS_OUT ? eio_pkg::SPAN_TWO_IN_OUT : eio_pkg::SPAN_TWO_IN;
  localparam logic [15:0] RST_FB_MODE =
    ONE_OUT ? eio_pkg::RST_FB_ONE_OUT : eio_pkg::RST_FB_IN_OUT;

  // storage
  logic [7:0]  disc_mode;
  logic [7:0]  disc_level;
  logic [15:0] rng   [NCH];
  logic [15:0] unit  [NCH];
  logic [15:0] smin  [NCH];
  logic [15:0] smax  [NCH];
  logic [15:0] fb_mode;
  logic [15:0] fb_value;
  logic        fb_meta;
  logic        fb_sync;

  // bus state
  logic        aw_got;
  logic        w_got;
  logic [7:0]  aw_idx;
  logic [15:0] w_data;
  logic [1:0]  w_strb;

  // analog address decode, shared by read and write paths
  function automatic logic [5:0] ana_off(input logic [7:0] idx);
    ana_off = 6'(idx - eio_pkg::IDX_ANA_BASE);
  endfunction : ana_off

  function automatic logic ana_hit(input logic [7:0] idx);
    ana_hit = (idx >= eio_pkg::IDX_ANA_BASE) &&
              (ana_off(idx) < SPAN) &&
              (idx < eio_pkg::IDX_ANA_BASE + 8'h40);
  endfunction : ana_hit

  // channel 2 is always the output channel when present
  function automatic logic [1:0] ana_ch(input logic [5:0] off);
    if (ONE_OUT || off >= eio_pkg::OUT_CH_OFF) begin
      ana_ch = 2'd2;
    end else begin
      ana_ch = {1'b0, off[2]};
    end
  endfunction : ana_ch

  function automatic logic [2:0] ana_fld(input logic [5:0] off);
    if (ONE_OUT) begin
      ana_fld = off[2:0];
    end else if (off >= eio_pkg::OUT_CH_OFF) begin
      ana_fld = 3'(off - eio_pkg::OUT_CH_OFF);
    end else begin
      ana_fld = {1'b0, off[1:0]};
    end
  endfunction : ana_fld

  function automatic logic [15:0] reg_val(input logic [7:0] idx);
    logic [5:0] off;
    logic [1:0] ch;
    off = ana_off(idx);
    ch  = ana_ch(off);
    reg_val = 16'h0000;
    if (idx == eio_pkg::IDX_DISC_MODE) begin
      reg_val = {8'h00, disc_mode};
    end else if (idx == eio_pkg::IDX_DISC_LEVEL) begin
      reg_val = {8'h00, disc_level};
    end else if (idx == eio_pkg::IDX_INFO) begin
      reg_val = {8'h00, 1'b0, MIX_ALLOWED, MODULE_TYPE,
                 eio_pkg::RES_BITS[3:0]};
    end else if (idx == eio_pkg::IDX_DISC_STATE) begin
      reg_val = {7'h00, fb_sync, disc_out};
    end else if (ana_hit(idx)) begin
      case (ana_fld(off))
        eio_pkg::FLD_RANGE:    reg_val = rng[ch];
        eio_pkg::FLD_UNIT:     reg_val = unit[ch];
        eio_pkg::FLD_MIN:      reg_val = smin[ch];
        eio_pkg::FLD_MAX:      reg_val = smax[ch];
        eio_pkg::FLD_FB_MODE:  reg_val = fb_mode;
        eio_pkg::FLD_FB_VALUE: reg_val = fb_value;
        default:               reg_val = 16'h0000;
      endcase
    end
  endfunction : reg_val

  function automatic logic [2:0] kind_of(input logic [15:0] code);
    if (code == eio_pkg::RNG_UNUSED) begin
      kind_of = eio_pkg::KIND_UNUSED;
    end else if (code <= eio_pkg::RNG_4_20MA) begin
      kind_of = eio_pkg::KIND_CURRENT;
    end else if (code <= eio_pkg::RNG_PM10V) begin
      kind_of = eio_pkg::KIND_VOLTAGE;
    end else if (code <= eio_pkg::RNG_TC_LAST) begin
      kind_of = eio_pkg::KIND_THERMO;
    end else if (code <= eio_pkg::RNG_RTD_LAST) begin
      kind_of = eio_pkg::KIND_RTD;
    end else if (code == eio_pkg::RNG_TEMP) begin
      kind_of = eio_pkg::KIND_TEMP;
    end else begin
      kind_of = eio_pkg::KIND_INVALID;
    end
  endfunction : kind_of

  // write path decode
  wire logic        wr_go   = aw_got && w_got && !s_axi_bvalid;
  wire logic [5:0]  wr_off  = ana_off(aw_idx);
  wire logic [1:0]  wr_ch   = ana_ch(wr_off);
  wire logic [2:0]  wr_fld  = ana_fld(wr_off);
  wire logic        wr_ana  = ana_hit(aw_idx);
  wire logic [15:0] wr_old  = reg_val(aw_idx);
  wire logic [15:0] wr_val  = {w_strb[1] ? w_data[15:8] : wr_old[15:8],
                               w_strb[0] ? w_data[7:0]  : wr_old[7:0]};
  wire logic        wr_disc = (aw_idx == eio_pkg::IDX_DISC_MODE) ||
                              (aw_idx == eio_pkg::IDX_DISC_LEVEL);
  wire logic        wr_ro   = (aw_idx == eio_pkg::IDX_INFO) ||
                              (aw_idx == eio_pkg::IDX_DISC_STATE);
  wire logic        wr_rng  = wr_ana && (wr_fld == eio_pkg::FLD_RANGE);
  // input and output channels of these types take only 0, 2 and 3
  wire logic rng_legal = (wr_val == eio_pkg::RNG_UNUSED) ||
                         (wr_val == eio_pkg::RNG_4_20MA) ||
                         (wr_val == eio_pkg::RNG_0_10V);
  // unmixable types: a used range must equal every other used range
  logic mix_ok;
  always_comb begin
    mix_ok = 1'b1;
    for (int c = 0; c < NCH; c++) begin
      if (!MIX_ALLOWED && c != int'(wr_ch) &&
          wr_val != eio_pkg::RNG_UNUSED &&
          rng[c] != eio_pkg::RNG_UNUSED && rng[c] != wr_val) begin
        mix_ok = 1'b0;
      end
    end
  end
  wire logic wr_ok = wr_disc ||
                     (wr_ana && (!wr_rng || (rng_legal && mix_ok)));
  wire logic [1:0] wr_resp = wr_ok ? eio_pkg::RESP_OKAY :
                                     eio_pkg::RESP_SLVERR;

  // read path decode
  wire logic [7:0]  rd_idx = s_axi_araddr[9:2];
  wire logic        rd_ok  = (s_axi_araddr[31:10] == 22'h000000) &&
                             (rd_idx <= eio_pkg::IDX_DISC_STATE ||
                              ana_hit(rd_idx));
  wire logic [31:0] rd_val = {16'h0000, reg_val(rd_idx)};
  wire logic        aw_ok  = (s_axi_awaddr[31:10] == 22'h000000);

  // fallback steering
  wire logic fb_apply = ONE_OUT ? !fb_mode[0] : fb_mode[0];
  wire logic [7:0] disc_fb = (disc_mode & disc_level) |
                             (~disc_mode & disc_out);

  // axi write channel handling; address and data taken in either order
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= eio_pkg::RESP_OKAY;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_idx        <= 8'h00;
      w_data        <= 16'h0000;
      w_strb        <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_got        <= 1'b1;
        // out-of-window addresses park on an index nothing decodes
        aw_idx        <= aw_ok ? s_axi_awaddr[9:2] : 8'hff;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_got        <= 1'b1;
        w_data       <= s_axi_wdata[15:0];
        w_strb       <= s_axi_wstrb[1:0];
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_resp;
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // register storage; refused writes leave contents untouched
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      disc_mode  <= eio_pkg::RST_DISC_MODE;
      disc_level <= eio_pkg::RST_DISC_LEVEL;
      fb_mode    <= RST_FB_MODE;
      fb_value   <= eio_pkg::RST_FB_VALUE;
      for (int c = 0; c < NCH; c++) begin
        rng[c]  <= eio_pkg::RST_RANGE;
        unit[c] <= eio_pkg::RST_UNIT;
        smin[c] <= eio_pkg::RST_MIN;
        smax[c] <= eio_pkg::RST_MAX;
      end
    end else if (wr_go && wr_ok && !wr_ro) begin
      if (aw_idx == eio_pkg::IDX_DISC_MODE) begin
        disc_mode <= wr_val[7:0];
      end else if (aw_idx == eio_pkg::IDX_DISC_LEVEL) begin
        disc_level <= wr_val[7:0];
      end else begin
        case (wr_fld)
          eio_pkg::FLD_RANGE:    rng[wr_ch]  <= wr_val;
          eio_pkg::FLD_UNIT:     unit[wr_ch] <= wr_val;
          eio_pkg::FLD_MIN:      smin[wr_ch] <= wr_val;
          eio_pkg::FLD_MAX:      smax[wr_ch] <= wr_val;
          eio_pkg::FLD_FB_MODE:  fb_mode     <= wr_val;
          eio_pkg::FLD_FB_VALUE: fb_value    <= wr_val;
          default:               fb_value    <= fb_value;
        endcase
      end
    end
  end

  // axi read channel, data one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= eio_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_ok ? rd_val : 32'h00000000;
      s_axi_rresp   <= rd_ok ? eio_pkg::RESP_OKAY : eio_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // fallback request is asynchronous to clk
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fb_meta <= 1'b0;
      fb_sync <= 1'b0;
    end else begin
      fb_meta <= fallback_req;
      fb_sync <= fb_meta;
    end
  end

  // outputs follow commands until fallback, then level or hold per mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      disc_out <= 8'h00;
      ana_out  <= 16'h0000;
    end else if (fb_sync) begin
      disc_out <= disc_fb;
      if (HAS_OUT && fb_apply) begin
        ana_out <= fb_value;
      end
    end else begin
      disc_out <= disc_cmd;
      ana_out  <= HAS_OUT ? ana_cmd : 16'h0000;
    end
  end

  // per channel decode; custom scale only when unit is customized
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      range_kind <= 9'h000;
      scale_min  <= 48'h000000000000;
      scale_max  <= {3{eio_pkg::RST_MAX}};
    end else begin
      for (int c = 0; c < NCH; c++) begin
        range_kind[3*c +: 3] <= kind_of(rng[c]);
        scale_min[16*c +: 16] <= (unit[c] == eio_pkg::UNIT_CUSTOM) ?
                                 smin[c] : eio_pkg::RST_MIN;
        scale_max[16*c +: 16] <= (unit[c] == eio_pkg::UNIT_CUSTOM) ?
                                 smax[c] : eio_pkg::RST_MAX;
      end
    end
  end

endmodule : eio_param_regs

// File: eio_pkg.sv
// Purpose: constants for the expansion i/o parameter register bank
// Assumes: 32-bit axi4-lite, one word per register, byte addr = 4 * index
// Notes:   analog offsets are relative to the analog base index
package eio_pkg;
  // module personalities selectable at build time
  typedef enum logic [1:0] {
    EIO_TWO_IN     = 2'b00,
    EIO_ONE_OUT    = 2'b01,
    EIO_TWO_IN_OUT = 2'b11
  } eio_type_e;

  // register indices
  localparam logic [7:0]  IDX_DISC_MODE  = 8'h00;
  localparam logic [7:0]  IDX_DISC_LEVEL = 8'h01;
  localparam logic [7:0]  IDX_INFO       = 8'h02;
  localparam logic [7:0]  IDX_DISC_STATE = 8'h03;
  localparam logic [7:0]  IDX_ANA_BASE   = 8'h10;
  // analog field offsets inside a channel group
  localparam logic [2:0]  FLD_RANGE      = 3'h0;
  localparam logic [2:0]  FLD_UNIT       = 3'h1;
  localparam logic [2:0]  FLD_MIN        = 3'h2;
  localparam logic [2:0]  FLD_MAX        = 3'h3;
  localparam logic [2:0]  FLD_FB_MODE    = 3'h4;
  localparam logic [2:0]  FLD_FB_VALUE   = 3'h5;
  localparam logic [5:0]  OUT_CH_OFF     = 6'h08;
  localparam logic [5:0]  SPAN_TWO_IN    = 6'h08;
  localparam logic [5:0]  SPAN_ONE_OUT   = 6'h06;
  localparam logic [5:0]  SPAN_TWO_IN_OUT = 6'h0e;
  // reset values
  localparam logic [7:0]  RST_DISC_MODE  = 8'hff;
  localparam logic [7:0]  RST_DISC_LEVEL = 8'h00;
  localparam logic [15:0] RST_RANGE      = 16'h0000;
  localparam logic [15:0] RST_UNIT       = 16'h0001;
  localparam logic [15:0] RST_MIN        = 16'h0000;
  localparam logic [15:0] RST_MAX        = 16'h7fff;
  localparam logic [15:0] RST_FB_VALUE   = 16'h0000;
  localparam logic [15:0] RST_FB_ONE_OUT = 16'h0000;
  localparam logic [15:0] RST_FB_IN_OUT  = 16'h0001;
  // range and unit codes
  localparam logic [15:0] RNG_UNUSED     = 16'h0000;
  localparam logic [15:0] RNG_0_20MA     = 16'h0001;
  localparam logic [15:0] RNG_4_20MA     = 16'h0002;
  localparam logic [15:0] RNG_0_10V      = 16'h0003;
  localparam logic [15:0] RNG_PM10V      = 16'h0004;
  localparam logic [15:0] RNG_TC_LAST    = 16'h0007;
  localparam logic [15:0] RNG_RTD_LAST   = 16'h000b;
  localparam logic [15:0] RNG_TEMP       = 16'h000c;
  localparam logic [15:0] UNIT_CUSTOM    = 16'h0001;
  // decoded range kinds
  localparam logic [2:0]  KIND_UNUSED    = 3'h0;
  localparam logic [2:0]  KIND_CURRENT   = 3'h1;
  localparam logic [2:0]  KIND_VOLTAGE   = 3'h2;
  localparam logic [2:0]  KIND_THERMO    = 3'h3;
  localparam logic [2:0]  KIND_RTD       = 3'h4;
  localparam logic [2:0]  KIND_TEMP      = 3'h5;
  localparam logic [2:0]  KIND_INVALID   = 3'h7;
  localparam logic [4:0]  RES_BITS       = 5'h0c;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;
endpackage : eio_pkg

// File: eio_param_regs_checker.sv
// Purpose: bus handshake and output timing checks for eio_param_regs
// Assumes: sees only the top module ports, one clock domain
// Notes:   fallback content is compared by the bench, not here
`timescale 1ns/10ps
module eio_param_regs_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // outputs and their causes
  input wire logic        fallback_req,
  input wire logic [7:0]  disc_cmd,
  input wire logic [7:0]  disc_out,
  input wire logic [8:0]  range_kind
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // answer is registered one cycle after both halves are held
  property p_b_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("no write answer");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_w_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_busy: assert property (p_w_busy) else $error("write taken while busy");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("no read answer");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_rdata_hi;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_rdata_hi: assert property (p_rdata_hi)
    else $error("upper data set");
  // five quiet samples cover the two sync flops plus the output flop
  property p_disc_follow;
    !fallback_req [*5] |-> disc_out == $past(disc_cmd);
  endproperty
  a_disc_follow: assert property (p_disc_follow)
    else $error("disc out");
  property p_kind_legal;
    range_kind[2:0] <= 3'h2 && range_kind[5:3] <= 3'h2
      && range_kind[8:6] <= 3'h2;
  endproperty
  a_kind_legal: assert property (p_kind_legal)
    else $error("bad kind");
endmodule : eio_param_regs_checker
bind eio_param_regs eio_param_regs_checker u_chk (.clk, .sys_rst,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .fallback_req, .disc_cmd, .disc_out, .range_kind);

// File: eio_param_regs_tb.sv
// Purpose: self-checking bench for eio_param_regs, mixed in/out type
// Assumes: byte address is four times the register index
// Notes:   random data from a fixed-seed lfsr, corner cases by hand
`timescale 1ns/10ps
module eio_param_regs_tb;
  logic        clk = 1'b0, sys_rst = 1'b1;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0]  s_axi_wstrb = 4'h3;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d, e, seed = 32'h0c831a4c;
  logic        fallback_req = 0;
  logic [7:0]  disc_cmd = '0, disc_out, m, l, h;
  logic [15:0] ana_cmd = '0, ana_out, a, v, last;
  logic [8:0]  range_kind;
  logic [47:0] scale_min, scale_max;
  int          miscompares = 0, comparisons = 0, cycles = 0;
  logic [7:0]  ri[8] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13,
                         8'h1c, 8'h1d};
  logic [15:0] rv[8] = '{16'h00ff, 16'h0000, 16'h0000, 16'h0001,
                         16'h0000, 16'h7fff, 16'h0001, 16'h0000};

  eio_param_regs u_dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fallback_req, .disc_cmd,
    .ana_cmd, .disc_out, .ana_out, .range_kind, .scale_min, .scale_max);

  always #5 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [2:0] exp_kind(input logic [15:0] c);
    return (c == 16'h0002) ? 3'h1 : (c == 16'h0003) ? 3'h2 : 3'h0;
  endfunction : exp_kind

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // ready is raised a cycle late so the answer must stand while stalled
  task automatic wr(input logic [7:0] i, input logic [31:0] dd,
                    output logic [1:0] rr);
    s_axi_awaddr <= {22'h0, i, 2'b00};
    s_axi_wdata <= dd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] i, output logic [31:0] dd,
                    output logic [1:0] rr);
    s_axi_araddr <= {22'h0, i, 2'b00};
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    dd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rd(ri[i], d, r);
      chk("reset value", {16'h0, rv[i]}, d);
    end
    rd(8'h02, d, r);
    chk("resolution", 32'hc, {28'h0, d[3:0]});
    wr(8'h02, 32'h0, r);
    chk("ro write resp", 32'h2, {30'h0, r});
    rd(8'h1e, d, r);
    chk("unmapped data", 32'h0, d);
    chk("unmapped resp", 32'h2, {30'h0, r});
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      wr(8'h00, seed, r);
      rd(8'h00, d, r);
      chk("mode upper byte", {24'h0, seed[7:0]}, d);
    end
    last = 16'h0;
    for (int c = 0; c < 13; c++) begin
      wr(8'h10, 32'(c), r);
      if (c == 0 || c == 2 || c == 3) last = 16'(c);
      e = (last == 16'(c)) ? 32'h0 : 32'h2;
      chk("range resp", e, {30'h0, r});
      rd(8'h10, d, r);
      chk("range value", {16'h0, last}, d);
      e = {29'h0, exp_kind(last)};
      chk("range kind", e, {29'h0, range_kind[2:0]});
    end
    wr(8'h12, 32'h1234, r);
    wr(8'h13, 32'h5678, r);
    repeat (3) @(posedge clk);
    chk("custom min", 32'h1234, {16'h0, scale_min[15:0]});
    chk("custom max", 32'h5678, {16'h0, scale_max[15:0]});
    wr(8'h11, 32'h0, r);
    repeat (3) @(posedge clk);
    chk("normal min", 32'h0, {16'h0, scale_min[15:0]});
    chk("normal max", 32'h7fff, {16'h0, scale_max[15:0]});
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      m = (k == 0) ? 8'h00 : seed[7:0];
      l = seed[15:8];
      h = seed[23:16];
      a = seed[31:16];
      v = ~seed[15:0];
      // upper byte set on purpose: it must not reach any output
      wr(8'h00, {16'h0, 8'hff, m}, r);
      wr(8'h01, {16'h0, 8'hff, l}, r);
      wr(8'h1d, {16'h0, v}, r);
      disc_cmd <= h;
      ana_cmd <= a;
      repeat (4) @(posedge clk);
      chk("normal disc", {24'h0, h}, {24'h0, disc_out});
      fallback_req <= 1'b1;
      repeat (5) @(posedge clk);
      disc_cmd <= ~h;
      ana_cmd <= ~a;
      repeat (5) @(posedge clk);
      e = {24'h0, (m & l) | (~m & h)};
      chk("fallback disc", e, {24'h0, disc_out});
      rd(8'h03, d, r);
      chk("state", {23'h0, 1'b1, e[7:0]}, d);
      chk("fallback ana", {16'h0, v}, {16'h0, ana_out});
      wr(8'h01, {24'h0, ~l}, r);
      repeat (3) @(posedge clk);
      e = {24'h0, (m & ~l) | (~m & h)};
      chk("level change", e, {24'h0, disc_out});
      fallback_req <= 1'b0;
      repeat (5) @(posedge clk);
      chk("resume disc", {24'h0, ~h}, {24'h0, disc_out});
      chk("resume ana", {16'h0, ~a}, {16'h0, ana_out});
    end
    end_of_test();
  end
endmodule : eio_param_regs_tb
